// [logic/calendar_pkg.sv]
// Purpose: constants shared by the calendar/alarm register block
// Assumes: 16-bit register port, word offsets of our own
// Notes: masks zero the unimplemented bits on every write
`default_nettype none
package calendar_pkg;
    // =========================================================
    // register offsets
    localparam logic [2:0] OFF_ALARM_CONFIG_REPEAT = 3'h0;
    localparam logic [2:0] OFF_YEAR_VALUE = 3'h1;
    localparam logic [2:0] OFF_MONTH_DAY_VALUE = 3'h2;
    localparam logic [2:0] OFF_WEEKDAY_HOUR_VALUE = 3'h3;
    localparam logic [2:0] OFF_MINUTE_SECOND_VALUE = 3'h4;
    localparam logic [2:0] OFF_ALARM_VALUE_WINDOW = 3'h5;
    localparam logic [2:0] OFF_CALENDAR_CONTROL = 3'h6;
    // =========================================================
    // implemented-bit masks
    localparam logic [15:0] MASK_YEAR = 16'h00ff;
    localparam logic [15:0] MASK_MONTH_DAY = 16'h1f3f;
    localparam logic [15:0] MASK_WEEKDAY_HOUR = 16'h073f;
    localparam logic [15:0] MASK_MINUTE_SECOND = 16'h7f7f;
    localparam logic [15:0] MASK_CONTROL = 16'h0003;
    // =========================================================
    // field positions
    localparam int CFG_ENABLE_BIT = 15;
    localparam int CFG_INDEFINITE_REPEAT_BIT_BIT = 14;
    localparam int CTL_WREN_BIT = 0;
    localparam int CTL_RUN_BIT = 1;
    // =========================================================
    // alarm match interval codes
    localparam logic [3:0] AM_HALF_SECOND = 4'h0;
    localparam logic [3:0] AM_SECOND = 4'h1;
    localparam logic [3:0] AM_TEN_SECONDS = 4'h2;
    localparam logic [3:0] AM_MINUTE = 4'h3;
    localparam logic [3:0] AM_TEN_MINUTES = 4'h4;
    localparam logic [3:0] AM_HOUR = 4'h5;
    localparam logic [3:0] AM_DAY = 4'h6;
    localparam logic [3:0] AM_WEEK = 4'h7;
    localparam logic [3:0] AM_MONTH = 4'h8;
    localparam logic [3:0] AM_YEAR = 4'h9;
    // =========================================================
    // values after reset
    localparam logic [7:0] RST_YEAR = 8'h00;
    localparam logic [7:0] RST_MONTH = 8'h01;
    localparam logic [7:0] RST_DAY = 8'h01;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [15:0] RST_CONFIG = 16'h0000;
    localparam logic [15:0] RST_ALARM_VALUE = 16'h0000;
endpackage
`default_nettype wire

// [logic/calendar_alarm_regs.sv]
// Purpose: calendar counters, alarm value registers and repeat logic
// Assumes: seconds square wave from a slow foreign clock domain
// Notes: rising edge of the wave is a new second, falling edge a half second
//
// Contract
// - each alarm event at a nonzero count decrements the repeat count
// - zero wraps to ff only when indefinite_repeat_bit set
// - year tens digit in bits 7..4
// - year ones digit in bits 3..0
// - year bits 15..8 read zero
// - year writes need calendar write enable
// - month/day, weekday/hour writes need write enable
// - month tens is bit 12, 0 or 1
// - month ones in bits 11..8
// - day tens in bits 5..4
// - day ones in bits 3..0
// - weekday in bits 10..8, 0 to 6
// - hour tens in bits 5..4
// - hour ones in bits 3..0
// - minute tens in bits 14..12
// - minute ones in bits 11..8
// - second tens in bits 6..4
// - second ones in bits 3..0
// - last alarm at count zero clears enable
// - every alarm event raises an interrupt request
//
// Local design decisions: the placing of the registers and the strobed register port.
`default_nettype none
module calendar_alarm_regs
    import calendar_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [2:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [15:0] rdata,
    input wire logic seconds_wave,
    output logic alarm_irq
);
    // =========================================================
    // state
    typedef struct packed {
        logic [2:0] sync;
        logic stable;
        logic pend_sec;
        logic pend_half;
        logic wren;
        logic run;
        logic alarm_enable_bit;
        logic indefinite_repeat_bit;
        logic [3:0] alarm_match_interval;
        logic [1:0] alarm_value_pointer;
        logic [7:0] alarm_repeat_count;
        logic [7:0] yr;
        logic [7:0] mo;
        logic [7:0] dy;
        logic [7:0] wd;
        logic [7:0] hr;
        logic [7:0] mi;
        logic [7:0] se;
        logic [15:0] alarm_minute_second;
        logic [15:0] alarm_weekday_hour;
        logic [15:0] alarm_month_day_value;
        logic irq;
        logic [15:0] rdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    // =========================================================
    // helpers
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        if (v[3:0] == 4'h9) begin
            r = {4'(v[7:4] + 4'h1), 4'h0};
        end else begin
            r = 8'(v + 8'h01);
        end
        return r;
    endfunction

    // bcd year divisible by four; century rule not needed for 00..99
    function automatic logic is_leap(input logic [7:0] y);
        logic r;
        r = 1'b0;
        if (!y[4]) begin
            r = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        end else begin
            r = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end
        return r;
    endfunction

    function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
        logic [7:0] r;
        r = 8'h31;
        case (m)
            8'h02: r = is_leap(y) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
            default: r = 8'h31;
        endcase
        return r;
    endfunction

    function automatic logic [7:0] lo8(input logic [15:0] v);
        return v[7:0];
    endfunction

    function automatic logic [7:0] hi8(input logic [15:0] v);
        return v[15:8];
    endfunction

    // implemented bits per word; applied on write and again on read
    function automatic logic [15:0] value_mask(input logic [2:0] a);
        logic [15:0] r;
        r = 16'h0000;
        case (a)
            OFF_ALARM_CONFIG_REPEAT: r = 16'hffff;
            OFF_YEAR_VALUE: r = MASK_YEAR;
            OFF_MONTH_DAY_VALUE: r = MASK_MONTH_DAY;
            OFF_WEEKDAY_HOUR_VALUE: r = MASK_WEEKDAY_HOUR;
            OFF_MINUTE_SECOND_VALUE: r = MASK_MINUTE_SECOND;
            OFF_ALARM_VALUE_WINDOW: r = 16'hffff;
            OFF_CALENDAR_CONTROL: r = MASK_CONTROL;
            default: r = 16'h0000;
        endcase
        return r;
    endfunction

    // pointer three has no word behind it, so nothing passes
    function automatic logic [15:0] window_mask(input logic [1:0] p);
        logic [15:0] r;
        r = 16'h0000;
        case (p)
            2'b00: r = MASK_MINUTE_SECOND;
            2'b01: r = MASK_WEEKDAY_HOUR;
            2'b10: r = MASK_MONTH_DAY;
            default: r = 16'h0000;
        endcase
        return r;
    endfunction

    // =========================================================
    // seconds input edges
    logic sec_rise;
    logic sec_fall;
    logic new_stable;
    logic cal_step;
    // a change only counts once the second and third stages agree
    assign new_stable = (s_q.sync[1] == s_q.sync[2]) ? s_q.sync[2] : s_q.stable;
    assign sec_rise = new_stable && !s_q.stable;
    assign sec_fall = !new_stable && s_q.stable;
    // counting halts while run is low so software can load a whole time
    assign cal_step = sec_rise && s_q.run;

    // =========================================================
    // alarm compare
    logic m_se1;
    logic m_se;
    logic m_mi1;
    logic m_mi;
    logic m_hr;
    logic m_wd;
    logic m_dy;
    logic m_mo;
    logic alarm_match;
    logic alarm_event;
    logic count_zero;

    assign m_se1 = s_q.se[3:0] == s_q.alarm_minute_second[3:0];
    assign m_se = s_q.se == lo8(s_q.alarm_minute_second);
    assign m_mi1 = s_q.mi[3:0] == s_q.alarm_minute_second[11:8];
    assign m_mi = s_q.mi == hi8(s_q.alarm_minute_second);
    assign m_hr = s_q.hr == lo8(s_q.alarm_weekday_hour);
    assign m_wd = s_q.wd == hi8(s_q.alarm_weekday_hour);
    assign m_dy = s_q.dy == lo8(s_q.alarm_month_day_value);
    assign m_mo = s_q.mo == hi8(s_q.alarm_month_day_value);

    always_comb begin
        case (s_q.alarm_match_interval)
            AM_HALF_SECOND: alarm_match = s_q.pend_half || s_q.pend_sec;
            AM_SECOND: alarm_match = s_q.pend_sec;
            AM_TEN_SECONDS: alarm_match = s_q.pend_sec && m_se1;
            AM_MINUTE: alarm_match = s_q.pend_sec && m_se;
            AM_TEN_MINUTES: alarm_match = s_q.pend_sec && m_se && m_mi1;
            AM_HOUR: alarm_match = s_q.pend_sec && m_se && m_mi;
            AM_DAY: alarm_match = s_q.pend_sec && m_se && m_mi && m_hr;
            AM_WEEK: alarm_match = s_q.pend_sec && m_se && m_mi && m_hr && m_wd;
            // feb 29 yearly only comes round in leap years by itself
            AM_MONTH: alarm_match = s_q.pend_sec && m_se && m_mi && m_hr && m_dy;
            AM_YEAR: alarm_match = s_q.pend_sec && m_se && m_mi && m_hr && m_dy && m_mo;
            default: alarm_match = 1'b0;
        endcase
    end

    assign alarm_event = s_q.alarm_enable_bit && alarm_match;
    // the alarm at count zero still fires; without indefinite repeat the enable drops only after it
    assign count_zero = s_q.alarm_repeat_count == 8'h00;

    // =========================================================
    // bus decode
    logic cal_write;
    logic [15:0] win_wdata;
    // calendar words stay locked until software sets the write enable
    assign cal_write = wr_en && s_q.wren;
    assign win_wdata = wdata & window_mask(s_q.alarm_value_pointer);

    // =========================================================
    // next state
    logic carry;

    always_comb begin
        s_d = s_q;
        carry = 1'b0;
        s_d.sync = {s_q.sync[1:0], seconds_wave};
        s_d.stable = new_stable;
        s_d.pend_sec = cal_step;
        s_d.pend_half = sec_fall && s_q.run;
        s_d.irq = alarm_event;
        s_d.rdata = 16'h0000;

        // calendar advance
        if (cal_step) begin
            carry = s_q.se == 8'h59;
            s_d.se = carry ? 8'h00 : bcd_inc(s_q.se);
            if (carry) begin
                carry = s_q.mi == 8'h59;
                s_d.mi = carry ? 8'h00 : bcd_inc(s_q.mi);
            end
            if (carry) begin
                carry = s_q.hr == 8'h23;
                s_d.hr = carry ? 8'h00 : bcd_inc(s_q.hr);
            end
            if (carry) begin
                s_d.wd = (s_q.wd == 8'h06) ? 8'h00 : 8'(s_q.wd + 8'h01);
                carry = s_q.dy == last_day(s_q.mo, s_q.yr);
                s_d.dy = carry ? 8'h01 : bcd_inc(s_q.dy);
            end
            if (carry) begin
                carry = s_q.mo == 8'h12;
                s_d.mo = carry ? 8'h01 : bcd_inc(s_q.mo);
            end
            if (carry) begin
                s_d.yr = (s_q.yr == 8'h99) ? 8'h00 : bcd_inc(s_q.yr);
            end
        end

        // repeat counting
        if (alarm_event) begin
            if (!count_zero) begin
                s_d.alarm_repeat_count = 8'(s_q.alarm_repeat_count - 8'h01);
            end else if (s_q.indefinite_repeat_bit) begin
                s_d.alarm_repeat_count = 8'hff;
            end else begin
                s_d.alarm_enable_bit = 1'b0;
            end
        end

        // software writes; a write lands after the hardware update
        if (wr_en) begin
            case (addr)
                OFF_ALARM_CONFIG_REPEAT: begin
                    s_d.alarm_enable_bit = wdata[CFG_ENABLE_BIT];
                    s_d.indefinite_repeat_bit = wdata[CFG_INDEFINITE_REPEAT_BIT_BIT];
                    s_d.alarm_match_interval = wdata[13:10];
                    s_d.alarm_value_pointer = wdata[9:8];
                    s_d.alarm_repeat_count = wdata[7:0];
                end
                OFF_YEAR_VALUE: begin
                    if (cal_write) begin
                        s_d.yr = lo8(wdata & value_mask(addr));
                    end
                end
                OFF_MONTH_DAY_VALUE: begin
                    if (cal_write) begin
                        {s_d.mo, s_d.dy} = wdata & value_mask(addr);
                    end
                end
                OFF_WEEKDAY_HOUR_VALUE: begin
                    if (cal_write) begin
                        {s_d.wd, s_d.hr} = wdata & value_mask(addr);
                    end
                end
                OFF_MINUTE_SECOND_VALUE: begin
                    if (cal_write) begin
                        {s_d.mi, s_d.se} = wdata & value_mask(addr);
                    end
                end
                OFF_ALARM_VALUE_WINDOW: begin
                    // no interlock on the enable bit: software owns that ordering
                    case (s_q.alarm_value_pointer)
                        2'b00: s_d.alarm_minute_second = win_wdata;
                        2'b01: s_d.alarm_weekday_hour = win_wdata;
                        2'b10: s_d.alarm_month_day_value = win_wdata;
                        default: ;
                    endcase
                end
                OFF_CALENDAR_CONTROL: begin
                    s_d.wren = wdata[CTL_WREN_BIT];
                    s_d.run = wdata[CTL_RUN_BIT];
                end
                default: ;
            endcase
        end

        // reads, answered one cycle later
        if (rd_en) begin
            case (addr)
                OFF_ALARM_CONFIG_REPEAT: begin
                    s_d.rdata = {s_q.alarm_enable_bit, s_q.indefinite_repeat_bit,
                                 s_q.alarm_match_interval, s_q.alarm_value_pointer,
                                 s_q.alarm_repeat_count};
                end
                OFF_YEAR_VALUE: s_d.rdata = {8'h00, s_q.yr};
                OFF_MONTH_DAY_VALUE: s_d.rdata = {s_q.mo, s_q.dy};
                OFF_WEEKDAY_HOUR_VALUE: s_d.rdata = {s_q.wd, s_q.hr};
                OFF_MINUTE_SECOND_VALUE: s_d.rdata = {s_q.mi, s_q.se};
                OFF_ALARM_VALUE_WINDOW: begin
                    case (s_q.alarm_value_pointer)
                        2'b00: s_d.rdata = s_q.alarm_minute_second;
                        2'b01: s_d.rdata = s_q.alarm_weekday_hour;
                        2'b10: s_d.rdata = s_q.alarm_month_day_value;
                        default: s_d.rdata = 16'h0000;
                    endcase
                end
                OFF_CALENDAR_CONTROL: begin
                    s_d.rdata = {14'h0000, s_q.run, s_q.wren} & MASK_CONTROL;
                end
                default: s_d.rdata = 16'h0000;
            endcase
            // spare bits read zero even if a stored word were ever disturbed
            s_d.rdata = s_d.rdata & value_mask(addr);
        end
    end

    // =========================================================
    // registers
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q.sync <= 3'h0;
            s_q.stable <= 1'b0;
            s_q.pend_sec <= 1'b0;
            s_q.pend_half <= 1'b0;
            s_q.wren <= 1'b0;
            s_q.run <= 1'b0;
            {s_q.alarm_enable_bit, s_q.indefinite_repeat_bit, s_q.alarm_match_interval,
             s_q.alarm_value_pointer, s_q.alarm_repeat_count} <= RST_CONFIG;
            s_q.yr <= RST_YEAR;
            s_q.mo <= RST_MONTH;
            s_q.dy <= RST_DAY;
            s_q.wd <= RST_ZERO;
            s_q.hr <= RST_ZERO;
            s_q.mi <= RST_ZERO;
            s_q.se <= RST_ZERO;
            s_q.alarm_minute_second <= RST_ALARM_VALUE;
            s_q.alarm_weekday_hour <= RST_ALARM_VALUE;
            s_q.alarm_month_day_value <= RST_ALARM_VALUE;
            s_q.irq <= 1'b0;
            s_q.rdata <= 16'h0000;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;
    assign alarm_irq = s_q.irq;

endmodule // calendar_alarm_regs
`default_nettype wire

// [tb/calendar_alarm_regs_sva.sv]
// Purpose: port-level checks for the calendar register block
// Assumes: alarm pointer changes only by software writes
// Notes: irq check leans on the short seconds synchroniser delay
`default_nettype none
module calendar_alarm_regs_sva
    import calendar_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [2:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [15:0] rdata,
    input wire logic seconds_wave,
    input wire logic alarm_irq
);
    // ==========================================
    // pointer shadow
    logic [1:0] ptr_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            ptr_q <= 2'h0;
        end else if (wr_en && addr == OFF_ALARM_CONFIG_REPEAT) begin
            ptr_q <= wdata[9:8];
        end
    end
    // ==========================================
    // properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_rdata_idle: assert property (!rd_en |=> rdata == 16'h0000)
        else $error("read data not zero outside a read");
    a_year_upper: assert property (rd_en && addr == OFF_YEAR_VALUE |=> rdata[15:8] == 8'h00)
        else $error("year upper byte not zero");
    a_mday_bits: assert property (rd_en && addr == OFF_MONTH_DAY_VALUE
        |=> (rdata & ~MASK_MONTH_DAY) == 16'h0000)
        else $error("month/day spare bits set");
    a_whour_bits: assert property (rd_en && addr == OFF_WEEKDAY_HOUR_VALUE
        |=> (rdata & ~MASK_WEEKDAY_HOUR) == 16'h0000)
        else $error("weekday/hour spare bits set");
    a_minute_second_value_bits: assert property (rd_en && addr == OFF_MINUTE_SECOND_VALUE
        |=> (rdata & ~MASK_MINUTE_SECOND) == 16'h0000)
        else $error("minute/second spare bits set");
    a_ptr_none: assert property (rd_en && addr == OFF_ALARM_VALUE_WINDOW && ptr_q == 2'h3
        |=> rdata == 16'h0000)
        else $error("pointer three read not zero");
    a_irq_single: assert property (alarm_irq |=> !alarm_irq)
        else $error("alarm pulse longer than one cycle");
    a_irq_cause: assert property ($stable(seconds_wave) [*8] |-> !alarm_irq)
        else $error("alarm without a seconds edge");
endmodule // calendar_alarm_regs_sva
bind calendar_alarm_regs calendar_alarm_regs_sva calendar_alarm_regs_sva_i(.clk(clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .seconds_wave(seconds_wave), .alarm_irq(alarm_irq));
`default_nettype wire

// [tb/testbench.sv]
// Purpose: self-checking bench for the calendar register block
// Assumes: seconds wave held 20 clocks per level, far slower than the sync
// Notes: register model is an array updated by each bus write the block accepts
`default_nettype none
module testbench
    import calendar_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, reset = 1'b1, wr_en = 1'b0, rd_en = 1'b0, seconds_wave = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [15:0] wdata = 16'h0000, rdata;
    logic alarm_irq;
    logic [31:0] rs = 32'h0000005a;
    logic [15:0] mdl [8];
    logic [15:0] win [4];
    int miscompares = 0, num_checks = 0, irqs = 0, n;
    // rollover cases: year, month/day, weekday/hour in, then expected after one second
    logic [15:0] rc [4][6] = '{'{16'h0099, 16'h1231, 16'h0623, 16'h0000, 16'h0101, 16'h0000},
        '{16'h0024, 16'h0228, 16'h0123, 16'h0024, 16'h0229, 16'h0200},
        '{16'h0023, 16'h0228, 16'h0123, 16'h0023, 16'h0301, 16'h0200},
        '{16'h0021, 16'h0430, 16'h0323, 16'h0021, 16'h0501, 16'h0400}};
    logic [3:0] cd [10] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
    int ne [10] = '{2, 1, 1, 1, 0, 0, 0, 0, 0, 0};
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (alarm_irq === 1'b1) begin
            irqs <= irqs + 1;
        end
    end
    calendar_alarm_regs calendar_alarm_regs_i(.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .seconds_wave(seconds_wave), .alarm_irq(alarm_irq));
    // ==========================================
    // helpers
    function automatic logic [15:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs[15:0];
    endfunction
    function automatic logic [15:0] msk(input int a);
        case (a)
            1: return MASK_YEAR;
            2: return MASK_MONTH_DAY;
            3: return MASK_WEEKDAY_HOUR;
            4: return MASK_MINUTE_SECOND;
            default: return 16'h0000;
        endcase
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // model follows write gating and masks; offset 7 stays zero
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        if (a == 3'h0) mdl[0] = d;
        if (a == 3'h6) mdl[6] = d & MASK_CONTROL;
        if (a >= 3'h1 && a <= 3'h4 && mdl[6][0]) mdl[a] = d & msk(int'(a));
        if (a == 3'h5 && mdl[0][9:8] != 2'h3) win[mdl[0][9:8]] = d & msk(4 - int'(mdl[0][9:8]));
    endtask
    task automatic ck(input logic [2:0] a);
        logic [15:0] e;
        e = (a == 3'h5) ? win[mdl[0][9:8]] : mdl[a];
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        check(rdata, e);
    endtask
    // one second: rise advances time, fall is the half second
    task automatic tick();
        @(posedge clk);
        seconds_wave <= 1'b1;
        repeat (20) @(posedge clk);
        seconds_wave <= 1'b0;
        repeat (20) @(posedge clk);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        print_verdict();
    end
    // ==========================================
    // main sequence
    initial begin
        for (int i = 0; i < 8; i++) mdl[i] = 16'h0000;
        for (int i = 0; i < 4; i++) win[i] = 16'h0000;
        mdl[2] = {3'h0, RST_MONTH[4:0], 2'h0, RST_DAY[5:0]};
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 8; i++) ck(3'(i));
        for (int i = 1; i < 5; i++) wr(3'(i), rnd());
        for (int i = 1; i < 5; i++) ck(3'(i));
        wr(3'h6, 16'h0001);
        for (int i = 1; i < 5; i++) wr(3'(i), rnd());
        for (int i = 1; i < 8; i++) ck(3'(i));
        wr(3'h7, rnd());
        ck(3'h7);
        wr(3'h6, 16'h0003);
        for (int c = 0; c < 4; c++) begin
            wr(3'h1, rc[c][0]);
            wr(3'h2, rc[c][1]);
            wr(3'h3, rc[c][2]);
            wr(3'h4, 16'h5959);
            tick();
            mdl[1] = rc[c][3];
            mdl[2] = rc[c][4];
            mdl[3] = rc[c][5];
            mdl[4] = 16'h0000;
            for (int i = 1; i < 5; i++) ck(3'(i));
        end
        check(16'(irqs), 16'h0000);
        // alarm values written only while the alarm is off
        for (int p = 0; p < 4; p++) begin
            wr(3'h0, 16'(p << 8));
            wr(3'h5, (p == 0) ? 16'h0001 : (p == 2) ? 16'h0101 : (p == 1) ? 16'h0000 : rnd());
            ck(3'h5);
        end
        for (int k = 0; k < 10; k++) begin
            wr(3'h1, 16'h0000);
            wr(3'h2, 16'h0101);
            wr(3'h3, 16'h0000);
            wr(3'h4, 16'h0000);
            n = irqs;
            wr(3'h0, 16'h8001 | 16'(cd[k]) << 10);
            tick();
            check(16'(irqs - n), 16'(ne[k]));
            mdl[0] = (ne[k] < 2 ? 16'h8000 : 16'h0000) | 16'(cd[k]) << 10 | 16'(ne[k] == 0);
            ck(3'h0);
        end
        wr(3'h0, 16'hc000 | 16'(AM_SECOND) << 10);
        tick();
        mdl[0] = mdl[0] | 16'h00ff;
        ck(3'h0);
        tick();
        mdl[0] = mdl[0] - 16'h0001;
        ck(3'h0);
        wr(3'h0, 16'h0000);
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
